// [mlbm_master.sv]
`timescale 1ns/1ps
// Contract
// - System clock output is input divided four
// - Address phase drives 15-bit address plus flag
// - Flag is inverted status bit 8; I/O high
// - Workspace/flag-word cycles output status on address
// - Strobe low: lines form 16-bit data bus
// - Others drive on read; we drive on write
// - Serial I/O reads first line, writes last
// - All shared lines float during hold
// - Each cycle opens with one strobe pulse
// - Storage signal and code stable while strobe low
// - Grant code, final strobe fall, then float
// - Storage signal low for memory, else high
// - Storage, read, write strobes float in hold
// - Write strobe low only with valid data
// - Write strobe per memory, serial, parallel, microcode
// - Read strobe low for reads; others drive then
// - Direction valid at cycle start, high reads
// - Drive data when direction low, else float
// - Ready low inserts wait states, sampled each state
// - Bus request gives grant code, float, resume
// - Cycle-type code floats during hold
module mlbm_master (
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire logic req_in,
    input wire logic [1:0] req_kind_in,
    input wire logic req_write_in,
    input wire logic [2:0] req_code_in,
    input wire logic [14:0] req_addr_in,
    input wire logic req_status8_in,
    input wire logic [15:0] req_wdata_in,
    input wire logic [15:0] req_status_in,
    input wire logic ready_in,
    input wire logic hold_req_n_in,
    input wire logic [15:0] ad_in,
    output logic busy_out,
    output logic done_out,
    output logic [15:0] rdata_out,
    output logic system_clock_out,
    output logic addr_phase_strobe_out,
    output logic strobe_oe_n_out,
    output logic [15:0] ad_out,
    output logic ad_oe_n_out,
    output logic storage_cycle_n_out,
    output logic read_strobe_n_out,
    output logic write_strobe_n_out,
    output logic direction_out,
    output logic ctl_oe_n_out,
    output logic [2:0] cycle_type_code_out,
    output logic code_oe_n_out
);

    // ==========================================================
    // Helpers
    function automatic logic write_ok(input logic [1:0] k, input logic [2:0] c,
                                      input logic top);
        write_ok = (k == mlbm_pkg::K_MEM) ||
                   (k == mlbm_pkg::K_IO && c[mlbm_pkg::MID_BIT]) ||
                   (k == mlbm_pkg::K_MACRO && !c[mlbm_pkg::MID_BIT]);
        if (k == mlbm_pkg::K_IO && !top && !c[mlbm_pkg::MID_BIT])
            write_ok = 1'b0;
    endfunction

    function automatic logic is_serial(input logic [1:0] k, input logic top);
        is_serial = (k == mlbm_pkg::K_IO) && !top;
    endfunction

    // ==========================================================
    // Synchronisers; first stages feed only second stages
    logic ready_m, ready_s, hold_m, hold_n_s;
    logic [15:0] ad_m, ad_s;

    always_ff @(posedge clk_sys_in)
    begin
        ready_m <= ready_in;
        ready_s <= ready_m;
        hold_m <= hold_req_n_in;
        hold_n_s <= hold_m;
        ad_m <= ad_in;
        ad_s <= ad_m;
    end

    // ==========================================================
    // Divide by four; one bus state per system clock period
    logic [1:0] ph;
    wire [1:0] next_ph = 2'(ph + 2'h1);
    wire tick = (ph == mlbm_pkg::PH_LAST);

    always_ff @(posedge clk_sys_in)
    begin
        if (!resetn_in)
        begin
            ph <= 2'h0;
            system_clock_out <= 1'b1;
        end
        else
        begin
            ph <= next_ph;
            system_clock_out <= (next_ph < mlbm_pkg::PH_HALF);
        end
    end

    // ==========================================================
    // Request latch
    mlbm_pkg::mlbm_state_e state, next_state;
    logic [1:0] lr_kind;
    logic lr_write, lr_s8;
    logic [2:0] lr_code;
    logic [14:0] lr_addr;
    logic [15:0] lr_wdata, lr_status;
    wire take = tick && state == mlbm_pkg::S_IDLE && hold_n_s && req_in;

    always_ff @(posedge clk_sys_in)
    begin
        if (!resetn_in)
        begin
            lr_kind <= mlbm_pkg::K_INT;
            lr_write <= 1'b0;
            lr_s8 <= 1'b0;
            lr_code <= 3'h0;
            lr_addr <= 15'h0000;
            lr_wdata <= mlbm_pkg::BUS_RESET;
            lr_status <= mlbm_pkg::BUS_RESET;
        end
        else if (take)
        begin
            lr_kind <= req_kind_in;
            lr_write <= req_write_in;
            lr_s8 <= req_status8_in;
            lr_code <= req_code_in;
            lr_addr <= req_addr_in;
            lr_wdata <= req_wdata_in;
            lr_status <= req_status_in;
        end
    end

    // ==========================================================
    // Sequencer; hold request wins over a new cycle at idle
    always_comb
    begin
        next_state = state;
        case (state)
            mlbm_pkg::S_IDLE:
                if (!hold_n_s)
                    next_state = mlbm_pkg::S_HCODE;
                else if (req_in)
                    next_state = mlbm_pkg::S_ADDR;
            mlbm_pkg::S_ADDR:
                next_state = mlbm_pkg::S_DATA;
            mlbm_pkg::S_DATA:
                if (ready_s)
                    next_state = mlbm_pkg::S_IDLE;
            mlbm_pkg::S_HCODE:
                next_state = mlbm_pkg::S_HFALL;
            mlbm_pkg::S_HFALL:
                next_state = mlbm_pkg::S_HOLD;
            mlbm_pkg::S_HOLD:
                if (hold_n_s)
                    next_state = mlbm_pkg::S_IDLE;
            default:
                next_state = mlbm_pkg::S_IDLE;
        endcase
    end

    // ==========================================================
    // Next pin values; fields come from the inputs on the take tick
    wire in_idle = (state == mlbm_pkg::S_IDLE);
    wire [1:0] f_kind = in_idle ? req_kind_in : lr_kind;
    wire f_write = in_idle ? req_write_in : lr_write;
    wire [2:0] f_code = in_idle ? req_code_in : lr_code;
    wire [14:0] f_addr = in_idle ? req_addr_in : lr_addr;
    wire f_s8 = in_idle ? req_status8_in : lr_s8;
    wire [15:0] f_stat = in_idle ? req_status_in : lr_status;
    wire f_top = f_addr[mlbm_pkg::ADDR_TOP];
    wire f_int = (f_kind == mlbm_pkg::K_INT);
    wire f_mem = (f_kind == mlbm_pkg::K_MEM);
    wire f_ser = is_serial(f_kind, f_top);
    wire f_rd = !f_write && !f_int;
    wire f_wr = f_write && !f_int && write_ok(f_kind, f_code, f_top);
    wire f_stcyc = (f_code == mlbm_pkg::CODE_WS) || (f_code == mlbm_pkg::CODE_ST);
    wire f_flag = f_mem ? !f_s8 : 1'b1;
    wire [15:0] f_abus = f_stcyc ? f_stat : {f_addr, f_flag};
    wire [15:0] f_sw = lr_wdata[0] ? 16'h0001 : 16'h0000;
    wire [15:0] f_dbus = f_ser ? (f_sw << mlbm_pkg::SER_OUT_BIT) : lr_wdata;

    wire ns_addr = (next_state == mlbm_pkg::S_ADDR);
    wire ns_data = (next_state == mlbm_pkg::S_DATA);
    wire ns_hcode = (next_state == mlbm_pkg::S_HCODE);
    wire ns_hold = (next_state == mlbm_pkg::S_HOLD);
    wire ns_grant = ns_hcode || (next_state == mlbm_pkg::S_HFALL);

    wire next_dir = f_rd;
    wire next_strobe = ns_addr || ns_hcode;
    wire next_mem_n = ns_addr ? !f_mem : (ns_grant ? 1'b1 : storage_cycle_n_out);
    wire [2:0] next_code = ns_addr ? f_code
                         : (ns_grant ? mlbm_pkg::CODE_GRANT : cycle_type_code_out);
    wire next_rd_n = !(ns_data && f_rd);
    wire next_wr_n = !(ns_data && f_wr);
    wire [15:0] next_ad = ns_addr ? f_abus : (ns_data ? f_dbus : ad_out);
    // Lines float unless an address phase or a data phase with direction low is next
    wire next_ad_oe_n = !(ns_addr || (ns_data && !direction_out));
    wire [15:0] f_rin = is_serial(lr_kind, lr_addr[mlbm_pkg::ADDR_TOP])
                        ? {15'h0000, ad_s[mlbm_pkg::SER_IN_BIT]} : ad_s;
    wire finish = tick && state == mlbm_pkg::S_DATA && ready_s;

    // ==========================================================
    // Pin registers, loaded once per system clock period
    always_ff @(posedge clk_sys_in)
    begin
        if (!resetn_in)
        begin
            state <= mlbm_pkg::S_IDLE;
            addr_phase_strobe_out <= 1'b0;
            strobe_oe_n_out <= 1'b0;
            ad_out <= mlbm_pkg::BUS_RESET;
            ad_oe_n_out <= 1'b1;
            storage_cycle_n_out <= 1'b1;
            read_strobe_n_out <= 1'b1;
            write_strobe_n_out <= 1'b1;
            direction_out <= 1'b1;
            ctl_oe_n_out <= 1'b0;
            cycle_type_code_out <= mlbm_pkg::CODE_GRANT;
            code_oe_n_out <= 1'b0;
        end
        else if (tick)
        begin
            state <= next_state;
            addr_phase_strobe_out <= next_strobe;
            strobe_oe_n_out <= ns_hold;
            ad_out <= next_ad;
            ad_oe_n_out <= next_ad_oe_n;
            storage_cycle_n_out <= next_mem_n;
            read_strobe_n_out <= next_rd_n;
            write_strobe_n_out <= next_wr_n;
            if (ns_addr)
                direction_out <= next_dir;
            ctl_oe_n_out <= ns_hold;
            cycle_type_code_out <= next_code;
            code_oe_n_out <= ns_hold;
        end
    end

    // Core-side answer; read data captured at the completing edge
    always_ff @(posedge clk_sys_in)
    begin
        if (!resetn_in)
        begin
            busy_out <= 1'b0;
            done_out <= 1'b0;
            rdata_out <= mlbm_pkg::BUS_RESET;
        end
        else
        begin
            done_out <= finish;
            if (take)
                busy_out <= 1'b1;
            else if (finish)
                busy_out <= 1'b0;
            if (finish && !lr_write)
                rdata_out <= f_rin;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!resetn_in);

    sequence grant_high_s;
        (addr_phase_strobe_out && cycle_type_code_out == mlbm_pkg::CODE_GRANT) [*4];
    endsequence

    sequence grant_low_s;
        (!addr_phase_strobe_out && cycle_type_code_out == mlbm_pkg::CODE_GRANT) [*4];
    endsequence

    // Reset stretches the first high phase; skip that rise
    clk_div_a: assert property ($rose(system_clock_out) && $past(resetn_in) |->
        system_clock_out [*2] ##1 !system_clock_out [*2] ##1 system_clock_out)
        else $error("system clock not divided by four");

    strobe_pulse_a: assert property (
        $rose(addr_phase_strobe_out) |-> addr_phase_strobe_out [*4] ##1 !addr_phase_strobe_out)
        else $error("address strobe pulse not one period");

    grant_seq_a: assert property (
        $rose(state == mlbm_pkg::S_HCODE) |-> grant_high_s ##1 grant_low_s ##1 strobe_oe_n_out)
        else $error("hold entry sequence wrong");

    code_stable_a: assert property (
        !addr_phase_strobe_out && $past(!addr_phase_strobe_out) && !code_oe_n_out
        |-> $stable(cycle_type_code_out) && $stable(storage_cycle_n_out))
        else $error("code or storage signal moved while strobe low");

    addr_phase_a: assert property (
        $rose(addr_phase_strobe_out) && state == mlbm_pkg::S_ADDR
        |-> storage_cycle_n_out == (lr_kind != mlbm_pkg::K_MEM)
            && direction_out == (!lr_write && lr_kind != mlbm_pkg::K_INT)
            && (lr_kind != mlbm_pkg::K_IO || ad_out[0] || lr_code == mlbm_pkg::CODE_WS
                || lr_code == mlbm_pkg::CODE_ST))
        else $error("address phase signals wrong");

    hold_float_a: assert property (state == mlbm_pkg::S_HOLD
        |-> ad_oe_n_out && ctl_oe_n_out && code_oe_n_out && strobe_oe_n_out)
        else $error("output driven during hold");

    write_data_a: assert property (!write_strobe_n_out && !ctl_oe_n_out
        |-> !ad_oe_n_out && !addr_phase_strobe_out && !direction_out)
        else $error("write strobe without driven data");

    read_float_a: assert property (!read_strobe_n_out
        |-> ad_oe_n_out && direction_out)
        else $error("bus driven during read");

    internal_quiet_a: assert property (
        state == mlbm_pkg::S_DATA && lr_kind == mlbm_pkg::K_INT
        |-> read_strobe_n_out && write_strobe_n_out)
        else $error("strobe active in internal cycle");

    ready_wait_a: assert property (
        tick && state == mlbm_pkg::S_DATA && !ready_s |=> state == mlbm_pkg::S_DATA)
        else $error("cycle ended while not ready");

    idle_float_a: assert property (state == mlbm_pkg::S_IDLE
        |-> ad_oe_n_out)
        else $error("shared lines driven while idle");

    serial_out_a: assert property (
        !write_strobe_n_out && !ctl_oe_n_out
        && is_serial(lr_kind, lr_addr[mlbm_pkg::ADDR_TOP])
        |-> ad_out[15:1] == 15'h0000)
        else $error("serial write drove more than the last line");

    io_write_a: assert property (
        !write_strobe_n_out && !ctl_oe_n_out && lr_kind == mlbm_pkg::K_IO
        |-> lr_code[mlbm_pkg::MID_BIT])
        else $error("write strobe on I/O cycle without middle code bit");

    grant_controls_a: assert property (state == mlbm_pkg::S_HFALL
        |-> storage_cycle_n_out && read_strobe_n_out && write_strobe_n_out && !ctl_oe_n_out)
        else $error("controls not high before hold float");

endmodule // mlbm_master

// [mlbm_pkg.sv]
package mlbm_pkg;

    // ==========================================================
    // Clock division
    localparam int SYS_DIV = 4;
    localparam logic [1:0] PH_LAST = 2'(SYS_DIV - 1);
    localparam logic [1:0] PH_HALF = 2'(SYS_DIV / 2);

    // ==========================================================
    // Cycle-type codes
    localparam logic [2:0] CODE_GRANT = 3'h7;
    localparam logic [2:0] CODE_WS = 3'h5;
    localparam logic [2:0] CODE_ST = 3'h6;
    localparam int MID_BIT = 1;

    // ==========================================================
    // Line positions; line 0 (address MSB) is bit 15
    localparam int ADDR_TOP = 14;
    localparam int SER_IN_BIT = 15;
    localparam int SER_OUT_BIT = 0;
    localparam logic [15:0] BUS_RESET = 16'h0000;

    // ==========================================================
    // Request kinds and sequencer states
    typedef enum logic [1:0] {
        K_MEM = 2'b00,
        K_IO = 2'b01,
        K_MACRO = 2'b10,
        K_INT = 2'b11
    } mlbm_kind_e;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_ADDR = 3'b001,
        S_DATA = 3'b010,
        S_HCODE = 3'b011,
        S_HFALL = 3'b100,
        S_HOLD = 3'b101
    } mlbm_state_e;

endpackage

// [mlbm_partner.sv]
`timescale 1ns/1ps
// ==========================================================
// Far side: memory, I/O and address latch
module mlbm_partner (
    input wire logic clk_sys_in,
    input wire logic strobe_in,
    input wire logic [15:0] drv_in,
    input wire logic drv_oe_n_in,
    input wire logic rd_n_in,
    input wire logic wr_n_in,
    input wire logic [3:0] wait_in,
    output logic [15:0] ad_out,
    output logic ready_out,
    output logic [15:0] wdata_out
);
    logic prev_strobe = 1'b0;
    logic [5:0] wait_cnt = 6'h00;
    logic [15:0] last_lvl = 16'h0000;
    logic [15:0] latched = 16'h0000;
    logic [15:0] rd_word;
    assign rd_word = latched ^ 16'hDA3D;
    // Undriven lines read back inverted, so a stale value never matches
    assign ad_out = !drv_oe_n_in ? drv_in : (!rd_n_in ? rd_word : ~last_lvl);
    assign ready_out = (wait_cnt == 6'h00);
    always @(posedge clk_sys_in)
    begin
        last_lvl <= ad_out;
        prev_strobe <= strobe_in;
        if (strobe_in)
            latched <= ad_out;
        if (prev_strobe && !strobe_in)
            wait_cnt <= {wait_in, 2'b00};
        else if (wait_cnt != 6'h00)
            wait_cnt <= wait_cnt - 6'h01;
        if (!wr_n_in)
            wdata_out <= ad_out;
    end
endmodule // mlbm_partner

// [mlbm_master_test.sv]
`timescale 1ns/1ps
module mlbm_master_test;
    logic clk_sys_in = 1'b0;
    logic resetn_in = 1'b0;
    logic req_in = 1'b0;
    logic [1:0] req_kind_in = 2'b00;
    logic req_write_in = 1'b0;
    logic [2:0] req_code_in = 3'h0;
    logic [14:0] req_addr_in = 15'h0000;
    logic req_status8_in = 1'b0;
    logic [15:0] req_wdata_in = 16'h0000;
    logic [15:0] req_status_in = 16'hBEEF;
    logic hold_req_n_in = 1'b1;
    logic [3:0] wait_set = 4'h0;
    wire logic ready_in;
    wire logic [15:0] ad_in;
    logic busy_out, done_out, system_clock_out, addr_phase_strobe_out, strobe_oe_n_out;
    logic ad_oe_n_out, storage_cycle_n_out, read_strobe_n_out, write_strobe_n_out;
    logic direction_out, ctl_oe_n_out, code_oe_n_out;
    logic [15:0] rdata_out, ad_out, p_wdata, m_addr;
    logic [2:0] cycle_type_code_out, m_code, prev_code;
    logic m_mem, m_dir, prev_stb, prev_mem;
    logic [7:0] sc;
    int fail_count = 0, n_compared = 0, n_pulse = 0, n_rd = 0, n_wr = 0, n_bad = 0, n_fall = 0;
    int len, base_len, p0, r0, w0;
    // Pull-ups hold floated read and write strobes high; a floated address strobe reads low
    wire logic pin_strobe = !strobe_oe_n_out && addr_phase_strobe_out;
    wire logic pin_rd_n = ctl_oe_n_out || read_strobe_n_out;
    wire logic pin_wr_n = ctl_oe_n_out || write_strobe_n_out;

    mlbm_master dut (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .req_in(req_in),
        .req_kind_in(req_kind_in), .req_write_in(req_write_in), .req_code_in(req_code_in),
        .req_addr_in(req_addr_in), .req_status8_in(req_status8_in),
        .req_wdata_in(req_wdata_in), .req_status_in(req_status_in), .ready_in(ready_in),
        .hold_req_n_in(hold_req_n_in), .ad_in(ad_in), .busy_out(busy_out),
        .done_out(done_out), .rdata_out(rdata_out), .system_clock_out(system_clock_out),
        .addr_phase_strobe_out(addr_phase_strobe_out), .strobe_oe_n_out(strobe_oe_n_out),
        .ad_out(ad_out), .ad_oe_n_out(ad_oe_n_out), .storage_cycle_n_out(storage_cycle_n_out),
        .read_strobe_n_out(read_strobe_n_out), .write_strobe_n_out(write_strobe_n_out),
        .direction_out(direction_out), .ctl_oe_n_out(ctl_oe_n_out),
        .cycle_type_code_out(cycle_type_code_out), .code_oe_n_out(code_oe_n_out));
    mlbm_partner far (.clk_sys_in(clk_sys_in), .strobe_in(pin_strobe), .drv_in(ad_out),
        .drv_oe_n_in(ad_oe_n_out), .rd_n_in(pin_rd_n), .wr_n_in(pin_wr_n),
        .wait_in(wait_set), .ad_out(ad_in), .ready_out(ready_in), .wdata_out(p_wdata));

    initial
    begin
        forever #20 clk_sys_in = ~clk_sys_in;
    end

    // ==========================================================
    // Bus monitor
    always @(posedge clk_sys_in)
    begin
        prev_stb <= pin_strobe;
        prev_mem <= storage_cycle_n_out;
        prev_code <= cycle_type_code_out;
        if (pin_strobe === 1'b1)
        begin
            m_addr <= ad_out;
            m_code <= cycle_type_code_out;
            m_mem <= storage_cycle_n_out;
            m_dir <= direction_out;
        end
        n_pulse <= n_pulse + int'(pin_strobe === 1'b1 && prev_stb === 1'b0);
        n_fall <= n_fall + int'(pin_strobe === 1'b0 && prev_stb === 1'b1);
        n_rd <= n_rd + int'(pin_rd_n === 1'b0);
        n_wr <= n_wr + int'(pin_wr_n === 1'b0);
        if (pin_strobe === 1'b0 && prev_stb === 1'b0 && busy_out === 1'b1
            && {storage_cycle_n_out, cycle_type_code_out} !== {prev_mem, prev_code})
            n_bad <= n_bad + 1;
    end

    // ==========================================================
    // Tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_compared++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_strb(input logic rd, input logic wr);
        chk(16'(n_pulse - p0), 16'h0001, "strobe pulses");
        chk(16'(n_rd != r0), 16'(rd), "read strobe");
        chk(16'(n_wr != w0), 16'(wr), "write strobe");
    endtask

    task automatic run_cycle(input logic [1:0] k, input logic w, input logic [2:0] c,
        input logic [14:0] a, input logic s8, input logic [15:0] d);
        int t;
        p0 = n_pulse;
        r0 = n_rd;
        w0 = n_wr;
        @(posedge clk_sys_in);
        req_kind_in <= k;
        req_write_in <= w;
        req_code_in <= c;
        req_addr_in <= a;
        req_status8_in <= s8;
        req_wdata_in <= d;
        req_in <= 1'b1;
        len = 0;
        t = 0;
        while (done_out !== 1'b1 && t < 300)
        begin
            @(posedge clk_sys_in);
            t++;
            len += int'(busy_out === 1'b1);
        end
        req_in <= 1'b0;
        #1;
        chk(16'(t < 300), 16'h0001, "cycle finished");
    endtask

    task automatic close_out();
        $display("compares %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        #2000000;
        fail_count++;
        $display("CHECK FAILED at %0t: watchdog ran out", $time);
        close_out();
    end

    // ==========================================================
    // Tests
    initial
    begin
        repeat (2) @(posedge clk_sys_in);
        resetn_in <= 1'b1;
        repeat (8)
        begin
            @(posedge clk_sys_in);
            #1;
            sc = {sc[6:0], system_clock_out};
        end
        chk(16'(sc ^ {sc[1:0], sc[7:2]}), 16'h00FF, "clock divide");
        $display("test clock done");
        run_cycle(mlbm_pkg::K_MEM, 1'b0, 3'h0, 15'h1234, 1'b1, 16'h0000);
        base_len = len;
        chk(16'(base_len), 16'h0008, "cycle length");
        chk(m_addr, 16'h2468, "mem address");
        chk(16'(m_mem), 16'h0000, "mem storage");
        chk(16'(m_dir), 16'h0001, "read direction");
        chk(rdata_out, 16'h2468 ^ 16'hDA3D, "mem read data");
        chk_strb(1'b1, 1'b0);
        run_cycle(mlbm_pkg::K_MEM, 1'b1, 3'h0, 15'h7FFF, 1'b0, 16'hC3A5);
        chk(m_addr, 16'hFFFF, "mem write address");
        chk(16'(m_dir), 16'h0000, "write direction");
        chk(p_wdata, 16'hC3A5, "mem write data");
        chk_strb(1'b0, 1'b1);
        $display("test memory done");
        for (int i = 0; i < 4; i++)
        begin
            run_cycle(i == 3 ? mlbm_pkg::K_MACRO : mlbm_pkg::K_IO, 1'b1, i < 2 ? 3'h2 : 3'h0,
                (i == 1 || i == 2) ? 15'h4005 : 15'h0005, 1'b0, i == 0 ? 16'h8001 : 16'h7FFE);
            chk(16'(m_mem), 16'h0001, "io storage");
            chk_strb(1'b0, i != 2);
            if (i < 3)
                chk(m_addr, (i == 0 || i == 3) ? 16'h000B : 16'h800B, "io address");
            if (i == 0)
                chk(p_wdata, 16'h0001, "serial write bit");
            if (i == 1)
                chk(p_wdata, 16'h7FFE, "parallel write");
        end
        run_cycle(mlbm_pkg::K_IO, 1'b0, 3'h2, 15'h0005, 1'b0, 16'h0000);
        chk(rdata_out, 16'h0001, "serial read");
        $display("test io done");
        for (int i = 0; i < 2; i++)
        begin
            run_cycle(mlbm_pkg::K_MEM, 1'b0, i == 0 ? mlbm_pkg::CODE_WS : mlbm_pkg::CODE_ST,
                15'h0100, 1'b0, 16'h0000);
            chk(m_addr, 16'hBEEF, "status on address");
            chk(16'(m_code), 16'(i == 0 ? mlbm_pkg::CODE_WS : mlbm_pkg::CODE_ST), "status code");
        end
        run_cycle(mlbm_pkg::K_INT, 1'b0, 3'h0, 15'h0010, 1'b0, 16'h0000);
        chk_strb(1'b0, 1'b0);
        chk(16'({m_mem, m_dir}), 16'h0002, "internal controls");
        chk(16'(n_bad), 16'h0000, "controls stable");
        $display("test status and internal done");
        @(posedge clk_sys_in);
        wait_set <= 4'h3;
        run_cycle(mlbm_pkg::K_MEM, 1'b0, 3'h0, 15'h1234, 1'b1, 16'h0000);
        chk(16'(len - base_len), 16'h000C, "wait states");
        chk(rdata_out, 16'h2468 ^ 16'hDA3D, "read after wait");
        wait_set <= 4'h0;
        $display("test wait done");
        r0 = n_fall;
        @(posedge clk_sys_in);
        hold_req_n_in <= 1'b0;
        len = 0;
        while (strobe_oe_n_out !== 1'b1 && len < 100)
        begin
            @(posedge clk_sys_in);
            len++;
        end
        #1;
        chk(16'(m_code), 16'h0007, "grant code");
        chk(16'(n_fall - r0), 16'h0001, "final strobe fall");
        chk(16'({ad_oe_n_out, ctl_oe_n_out, code_oe_n_out}), 16'h0007, "hold float");
        fork
            run_cycle(mlbm_pkg::K_MEM, 1'b0, 3'h0, 15'h0ABC, 1'b1, 16'h0000);
            begin
                repeat (12) @(posedge clk_sys_in);
                chk(16'(busy_out), 16'h0000, "busy in hold");
                hold_req_n_in <= 1'b1;
            end
        join
        chk(rdata_out, 16'h1578 ^ 16'hDA3D, "read after hold");
        $display("test hold done");
        close_out();
    end
endmodule // mlbm_master_test
